// File: design/eprom_prog_regs.vh
// Timing counts and pin-level constants for the memory programmer
`ifndef EPROM_PROG_REGS_VH
`define EPROM_PROG_REGS_VH
`define CLK_HZ 40000000
`define PULSE_MS 50
`define PULSE_MAX_MS 55
`define PULSE_CYCLES ((`CLK_HZ / 1000) * `PULSE_MS)
`define PULSE_MAX_CYCLES ((`CLK_HZ / 1000) * `PULSE_MAX_MS)
`define SETUP_CYCLES 40
`define VERIFY_CYCLES 40
`define ADDR_W 11
`define DATA_W 8
`define ERASED_WORD 8'hff
`endif

// File: design/eprom_programmer.v
// Host-side controller that reads, programs and verifies the memory via its pins
// Overview of operation
// RL1 - Memory holds 2048 eight-bit words, three-state
// RL2 - Six modes chosen by pin levels only
// RL3 - Strobe low, select low, 5 V: read
// RL4 - Strobe high at 5 V: power down
// RL5 - Power down floats all data outputs
// RL6 - Strobe low, select low, 25 V: verify
// RL7 - Erased bits high; programming only clears bits
// RL8 - Raise supply, select high, address, then data
// RL9 - Strobe high 50 ms, never over 55
// RL10 - Next word allowed once strobe is low
// RL11 - Release data, then select low to verify
// RL12 - Verify allowed with supply still high
// RL13 - Paralleled devices strobed together for wide words
// RL14 - Separate strobes; unwritten devices stay low
// RL15 - Select high at 5 V floats outputs
// RL16 - Hold lines stable; strobe only at 25 V
`timescale 1ns/1ps
`default_nettype none
`include "eprom_prog_regs.vh"
module eprom_programmer #(
    parameter NDEV = 1,
    parameter PULSE_CYCLES = `PULSE_CYCLES,
    parameter SETUP_CYCLES = `SETUP_CYCLES,
    parameter VERIFY_CYCLES = `VERIFY_CYCLES
) (
    input wire REF_CLK,
    input wire ARST_N,
    input wire CMD_READ,
    input wire CMD_PROG,
    input wire CMD_IDLE,
    input wire [NDEV-1:0] CMD_DEV_MASK,
    input wire [`ADDR_W-1:0] CMD_ADDR,
    input wire [NDEV*`DATA_W-1:0] CMD_DATA,
    output reg BUSY,
    output reg DONE,
    output reg VERIFY_ERR,
    output reg [NDEV*`DATA_W-1:0] RD_DATA,
    output reg VPP_HIGH,
    output reg CHIP_SELECT,
    output reg [NDEV-1:0] PROGRAM_STROBE_INPUT,
    output reg [`ADDR_W-1:0] ADDR,
    output reg [NDEV*`DATA_W-1:0] DATA_OUT,
    output reg DATA_OE_N,
    input wire [NDEV*`DATA_W-1:0] DATA_IN
);
    localparam DW = NDEV * `DATA_W;
    localparam TW = 22;
    localparam [3:0] S_IDLE = 4'h0, S_RD_SET = 4'h1, S_RD_CAP = 4'h2, S_VPP = 4'h3,
        S_SEL = 4'h4, S_ADDR = 4'h5, S_DATA = 4'h6, S_PULSE = 4'h7, S_REL = 4'h8,
        S_VSEL = 4'h9, S_VCAP = 4'ha, S_PDOWN = 4'hb;
    reg [3:0] st_q;
    reg [DW-1:0] din_s1_q, din_s2_q;
    reg [DW-1:0] wdata_q;
    reg [NDEV-1:0] mask_q;
    reg tload;
    reg [TW-1:0] tcount;
    wire tdone;
    integer i;
    reg [DW-1:0] expect_v;

    step_timer #(.W(TW)) u_timer (
        .clk(REF_CLK),
        .arst_n(ARST_N),
        .load(tload),
        .count(tcount),
        .done(tdone)
    );

    // Hard cap on the strobe width, independent of the phase timer
    localparam integer STB_LIMIT = `PULSE_MAX_CYCLES - 1;
    reg [TW-1:0] stb_len_q;
    wire stb_over = (stb_len_q == STB_LIMIT[TW-1:0]);
    always @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            stb_len_q <= {TW{1'b0}};
        end else if ((|PROGRAM_STROBE_INPUT) && VPP_HIGH && !stb_over) begin
            stb_len_q <= stb_len_q + {{(TW-1){1'b0}}, 1'b1};
        end else if (!(|PROGRAM_STROBE_INPUT)) begin
            stb_len_q <= {TW{1'b0}};
        end
    end

    // Read-back data crosses from pins
    always @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            din_s1_q <= {DW{1'b1}};
            din_s2_q <= {DW{1'b1}};
        end else begin
            din_s1_q <= DATA_IN;
            din_s2_q <= din_s1_q;
        end
    end

    // Expected verify word: masked bytes must read back as written
    always @* begin
        expect_v = din_s2_q; // RL7
        for (i = 0; i < NDEV; i = i + 1) begin
            if (mask_q[i])
                expect_v[i*`DATA_W +: `DATA_W] = wdata_q[i*`DATA_W +: `DATA_W];
        end
    end

    always @* begin
        tload = 1'b0;
        tcount = SETUP_CYCLES[TW-1:0];
        case (st_q)
            S_IDLE, S_PDOWN: tload = CMD_READ | CMD_PROG;
            S_VPP, S_SEL, S_ADDR: tload = tdone;
            S_DATA: begin
                tload = tdone;
                // Strobe falls the edge after done, so load one less
                tcount = PULSE_CYCLES[TW-1:0] - {{(TW-1){1'b0}}, 1'b1}; // RL9
            end
            S_PULSE: tload = tdone | stb_over; // RL9
            S_REL: tload = tdone;
            S_VSEL: begin
                tload = tdone;
                tcount = VERIFY_CYCLES[TW-1:0];
            end
            default: tload = 1'b0;
        endcase
    end

    always @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_q <= S_PDOWN;
            BUSY <= 1'b0;
            DONE <= 1'b0;
            VERIFY_ERR <= 1'b0;
            RD_DATA <= {DW{1'b0}};
            VPP_HIGH <= 1'b0;
            CHIP_SELECT <= 1'b1;
            PROGRAM_STROBE_INPUT <= {NDEV{1'b0}};
            ADDR <= {`ADDR_W{1'b0}};
            DATA_OUT <= {DW{1'b1}};
            DATA_OE_N <= 1'b1;
            wdata_q <= {DW{1'b1}};
            mask_q <= {NDEV{1'b0}};
        end else begin
            DONE <= 1'b0;
            case (st_q)
                S_PDOWN, S_IDLE: begin
                    BUSY <= 1'b0;
                    if (CMD_READ) begin
                        // Read mode at 5 V, strobe low (RL3)
                        st_q <= S_RD_SET;
                        BUSY <= 1'b1;
                        VPP_HIGH <= 1'b0;
                        PROGRAM_STROBE_INPUT <= {NDEV{1'b0}};
                        CHIP_SELECT <= 1'b0;
                        ADDR <= CMD_ADDR;
                        DATA_OE_N <= 1'b1;
                    end else if (CMD_PROG) begin
                        st_q <= S_VPP;
                        BUSY <= 1'b1;
                        VERIFY_ERR <= 1'b0;
                        VPP_HIGH <= 1'b1; // RL8
                        PROGRAM_STROBE_INPUT <= {NDEV{1'b0}};
                        wdata_q <= CMD_DATA;
                        mask_q <= CMD_DEV_MASK;
                    end else if (CMD_IDLE) begin
                        // Strobe high at 5 V parks devices in power down
                        st_q <= S_PDOWN; // RL4
                        VPP_HIGH <= 1'b0;
                        CHIP_SELECT <= 1'b1;
                        PROGRAM_STROBE_INPUT <= {NDEV{1'b1}};
                        DATA_OE_N <= 1'b1; // RL5
                    end
                end
                S_RD_SET: if (tdone) st_q <= S_RD_CAP;
                S_RD_CAP: begin
                    RD_DATA <= din_s2_q; // RL1
                    DONE <= 1'b1;
                    CHIP_SELECT <= 1'b1; // RL15
                    st_q <= S_IDLE;
                end
                S_VPP: if (tdone) begin
                    CHIP_SELECT <= 1'b1; // RL8
                    st_q <= S_SEL;
                end
                S_SEL: if (tdone) begin
                    ADDR <= CMD_ADDR; // RL8
                    st_q <= S_ADDR;
                end
                S_ADDR: if (tdone) begin
                    DATA_OUT <= wdata_q;
                    DATA_OE_N <= 1'b0;
                    st_q <= S_DATA;
                end
                S_DATA: if (tdone) begin
                    // Only selected devices get the pulse
                    if (VPP_HIGH) // RL16
                        PROGRAM_STROBE_INPUT <= mask_q; // RL13 RL14
                    st_q <= S_PULSE;
                end
                S_PULSE: if (tdone || stb_over) begin
                    PROGRAM_STROBE_INPUT <= {NDEV{1'b0}}; // RL9
                    st_q <= S_REL;
                end
                S_REL: if (tdone) begin
                    DATA_OE_N <= 1'b1; // RL11
                    st_q <= S_VSEL;
                end
                S_VSEL: if (tdone) begin
                    CHIP_SELECT <= 1'b0; // RL11 RL12
                    st_q <= S_VCAP;
                end
                S_VCAP: if (tdone) begin
                    // Verify with supply still at 25 V
                    RD_DATA <= din_s2_q; // RL6
                    VERIFY_ERR <= (din_s2_q != expect_v);
                    CHIP_SELECT <= 1'b1;
                    VPP_HIGH <= 1'b0;
                    DONE <= 1'b1; // RL10
                    st_q <= S_IDLE;
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end
endmodule // eprom_programmer
`default_nettype wire

// File: design/step_timer.v
// Down-counting delay timer used for setup, strobe and verify phases
`timescale 1ns/1ps
`default_nettype none
module step_timer #(
    parameter W = 22
) (
    input wire clk,
    input wire arst_n,
    input wire load,
    input wire [W-1:0] count,
    output reg done
);
    reg [W-1:0] cnt_q;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= {W{1'b0}};
            done <= 1'b0;
        end else if (load) begin
            cnt_q <= count;
            done <= 1'b0;
        end else if (cnt_q != {W{1'b0}}) begin
            cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
            done <= (cnt_q == {{(W-1){1'b0}}, 1'b1});
        end else begin
            done <= 1'b0;
        end
    end
endmodule // step_timer
`default_nettype wire

// File: sim/eprom_cell_model.sv
// Behavioural model of one 2048 x 8 erasable memory
`timescale 1ns/1ps
`default_nettype none
module eprom_cell_model (
    input wire logic vpp_high,
    input wire logic select,
    input wire logic strobe,
    input wire logic [10:0] addr,
    input wire logic [7:0] din,
    output wire logic [7:0] dout
);
    logic [7:0] mem [0:2047];
    logic [7:0] last;
    wire rd = !strobe && !select;
    initial begin
        last = 8'h00;
        foreach (mem[i]) mem[i] = 8'hff;
    end
    always @(negedge strobe) begin
        if (vpp_high && select) mem[addr] = mem[addr] & din;
    end
    // Released lines show the inverse of the last word
    always @(negedge rd) last = mem[addr];
    assign dout = rd ? mem[addr] : ~last;
endmodule // eprom_cell_model
`default_nettype wire

// File: sim/eprom_prog_checker.sv
// Assertions on the programmer pins
`timescale 1ns/1ps
`default_nettype none
`include "eprom_prog_regs.vh"
module eprom_prog_checker #(parameter NDEV = 2, parameter PULSE_CYCLES = 20) (
    input wire logic REF_CLK,
    input wire logic ARST_N,
    input wire logic BUSY,
    input wire logic VPP_HIGH,
    input wire logic CHIP_SELECT,
    input wire logic [NDEV-1:0] PROGRAM_STROBE_INPUT,
    input wire logic [`ADDR_W-1:0] ADDR,
    input wire logic [NDEV*`DATA_W-1:0] DATA_OUT,
    input wire logic DATA_OE_N
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);
    wire stb = |PROGRAM_STROBE_INPUT;
    int cnt_q;
    always @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) cnt_q <= 0;
        else cnt_q <= (stb && VPP_HIGH) ? cnt_q + 1 : 0;
    end
    a_strobe_needs_vpp: assert property ((stb && !DATA_OE_N) |-> VPP_HIGH)
        else $error("strobe without supply");
    a_lines_held: assert property ((stb && $past(stb) && VPP_HIGH) |-> $stable(ADDR)
        && $stable(DATA_OUT)) else $error("lines moved in pulse");
    a_pulse_max: assert property (cnt_q <= PULSE_CYCLES) else $error("pulse too long");
    a_pulse_exact: assert property ((!stb && cnt_q != 0) |-> cnt_q == PULSE_CYCLES)
        else $error("pulse width wrong");
    a_setup_strobe: assert property (($rose(stb) && VPP_HIGH) |-> CHIP_SELECT && !DATA_OE_N)
        else $error("strobe before setup");
    a_release_verify: assert property (($fell(CHIP_SELECT) && VPP_HIGH) |-> DATA_OE_N && !stb)
        else $error("verify with data driven");
    a_read_no_strobe: assert property (!CHIP_SELECT |-> !stb) else $error("strobe in read");
    a_idle_vpp_low: assert property (!BUSY |-> !VPP_HIGH) else $error("supply high idle");
endmodule // eprom_prog_checker
bind eprom_programmer eprom_prog_checker #(.NDEV(NDEV), .PULSE_CYCLES(PULSE_CYCLES)) u_chk (
    .REF_CLK(REF_CLK), .ARST_N(ARST_N), .BUSY(BUSY), .VPP_HIGH(VPP_HIGH),
    .CHIP_SELECT(CHIP_SELECT), .PROGRAM_STROBE_INPUT(PROGRAM_STROBE_INPUT), .ADDR(ADDR),
    .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N));
`default_nettype wire

// File: sim/eprom_programmer_tb_top.sv
// Testbench for the programmer with two paralleled memories
`timescale 1ns/1ps
`default_nettype none
module eprom_programmer_tb_top;
    logic clk = 0, arst_n = 0, rd = 0, pg = 0, idl = 0;
    logic [1:0] mask = 0;
    logic [10:0] addr = 0;
    logic [15:0] wdat = 0;
    wire busy, done, verr, vpp, sel, oe_n;
    wire [15:0] rdat, dout, dev_q, din;
    wire [1:0] stb;
    wire [10:0] pa;
    int error_cnt = 0, cmp_count = 0;
    assign din = oe_n ? dev_q : dout;
    eprom_programmer #(.NDEV(2), .PULSE_CYCLES(20), .SETUP_CYCLES(4), .VERIFY_CYCLES(4)) DUT (
        .REF_CLK(clk), .ARST_N(arst_n), .CMD_READ(rd), .CMD_PROG(pg), .CMD_IDLE(idl),
        .CMD_DEV_MASK(mask), .CMD_ADDR(addr), .CMD_DATA(wdat), .BUSY(busy), .DONE(done),
        .VERIFY_ERR(verr), .RD_DATA(rdat), .VPP_HIGH(vpp), .CHIP_SELECT(sel),
        .PROGRAM_STROBE_INPUT(stb), .ADDR(pa), .DATA_OUT(dout), .DATA_OE_N(oe_n), .DATA_IN(din));
    for (genvar i = 0; i < 2; i++) begin : g_mem
        eprom_cell_model u_mem (.vpp_high(vpp), .select(sel), .strobe(stb[i]), .addr(pa),
            .din(din[8*i+:8]), .dout(dev_q[8*i+:8]));
    end
    initial forever #12.5 clk = ~clk;
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task run(input logic r, p, input logic [1:0] m, input logic [10:0] a, input logic [15:0] d);
        @(negedge clk);
        {rd, pg, mask, addr, wdat} = {r, p, m, a, d};
        @(negedge clk);
        {rd, pg} = 2'b00;
        chk({15'h0000, busy}, 16'h0001);
        repeat (200) begin
            @(negedge clk);
            if (done === 1'b1) break;
        end
        chk({15'h0000, done}, 16'h0001);
    endtask
    task t_read_erased;
        run(1, 0, 2'b00, 11'h7ff, 16'h0000);
        chk(rdat, 16'hffff);
    endtask
    task t_prog_both;
        run(0, 1, 2'b11, 11'h005, 16'ha53c);
        chk(rdat, 16'ha53c);
        chk({15'h0000, verr}, 16'h0000);
    endtask
    task t_prog_one;
        run(0, 1, 2'b01, 11'h006, 16'h0f0f);
        chk({15'h0000, verr}, 16'h0000);
        run(1, 0, 2'b00, 11'h006, 16'h0000);
        chk(rdat, 16'hff0f);
    endtask
    task t_no_raise;
        run(0, 1, 2'b11, 11'h005, 16'hffff);
        chk({15'h0000, verr}, 16'h0001);
        chk(rdat, 16'ha53c);
    endtask
    task t_park;
        @(negedge clk);
        idl = 1;
        @(negedge clk);
        idl = 0;
        repeat (4) @(negedge clk);
        chk({13'h0000, stb, vpp}, 16'h0006);
        run(1, 0, 2'b00, 11'h005, 16'h0000);
        chk(rdat, 16'ha53c);
    endtask
    task close_out;
        $display("Checks %0d, errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge clk);
        chk({12'h000, vpp, oe_n, sel, |stb}, 16'h0006);
        arst_n = 1;
        t_read_erased();
        t_prog_both();
        t_prog_one();
        t_no_raise();
        t_park();
        close_out();
    end
    initial begin
        #(25 * 3000);
        error_cnt++;
        close_out();
    end
endmodule // eprom_programmer_tb_top
`default_nettype wire
